// ---- bbd_mem.sv ----
/*
 * bbd_pkg: shared encodings, field positions and state types for the
 * branch and bit-op decoder; bbd_mem: the small data memory behind it.
 * assumes one clock; the reset is synchronised inside bbd_core, not by the caller.
 */
package bbd_pkg;
	localparam int          BBD_PC_W      = 21;
	localparam int          BBD_DA_W      = 12;
	localparam int          BBD_BANK_W    = 4;
	localparam int          BBD_INSTR_W   = 16;
	localparam logic [3:0]  BBD_OPC_BRA   = 4'hd;
	localparam logic [3:0]  BBD_OPC_BSET  = 4'h8;
	localparam logic [3:0]  BBD_OPC_TCLR  = 4'hb;
	localparam logic [3:0]  BBD_OPC_TSET  = 4'ha;
	localparam int          BBD_OPC_HI    = 15;
	localparam int          BBD_OPC_LO    = 12;
	localparam int          BBD_OFF_HI    = 10;
	localparam int          BBD_BIT_HI    = 11;
	localparam int          BBD_BIT_LO    = 9;
	localparam int          BBD_AMODE_POS = 8;
	localparam int          BBD_REG_HI    = 7;
	localparam logic [15:0] BBD_NOP_WORD  = 16'h0000;
	localparam logic [7:0]  BBD_IDX_MAX   = 8'h5f;
	localparam logic [7:0]  BBD_ACC_SPLIT = 8'h80;
	localparam logic [3:0]  BBD_ACC_LO    = 4'h0;
	localparam logic [3:0]  BBD_ACC_HI    = 4'hf;
	localparam logic [1:0]  BBD_Q1        = 2'h0;
	localparam logic [1:0]  BBD_Q2        = 2'h1;
	localparam logic [1:0]  BBD_Q3        = 2'h2;
	localparam logic [1:0]  BBD_Q4        = 2'h3;
	localparam logic [1:0]  BBD_Q_STEP    = 2'h1;
	localparam logic [20:0] BBD_PC_STEP   = 21'h000002;
	localparam logic [20:0] BBD_PC_RESET  = 21'h000000;
	localparam logic [7:0]  BBD_BIT_ONE   = 8'h01;

	typedef enum logic [2:0] {
		BBD_OP_NONE,
		BBD_OP_BRANCH,
		BBD_OP_BITSET,
		BBD_OP_SKIPCLR,
		BBD_OP_SKIPSET
	} bbd_op_t;

	typedef struct packed {
		logic [1:0]             phase;
		logic [BBD_PC_W-1:0]    pc;
		logic [BBD_INSTR_W-1:0] ir;
		bbd_op_t                op;
		logic [BBD_DA_W-1:0]    addr;
		logic [2:0]             bsel;
		logic [7:0]             rbyte;
		logic [7:0]             wbyte;
		logic                   branch_taken;
		logic                   skip_taken;
		logic                   cycle_end;
	} bbd_state_t;

	typedef struct packed {
		logic                en;
		logic [BBD_DA_W-1:0] addr;
		logic [7:0]          data;
	} bbd_load_t;
endpackage

`timescale 1ns/1ns
module bbd_mem import bbd_pkg::*; #(
	parameter int AW = BBD_DA_W,
	parameter int DW = 8
) (
	// clock
	input  wire logic          clk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// read port, data one clock later
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array, contents are undefined until loaded
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ---- bbd_core.sv ----
/*
 * bbd_core: executes the unconditional relative branch, bit set in file
 * and the two bit-test skips of an 8-bit core over a four-phase cycle.
 * assumes fetch_word holds the word at prog_addr by the last phase of
 * every instruction cycle; other opcodes run as no_operation here.
 */
// How it works
// - top nibble 1101: branch, eleven-bit offset
// - pc becomes incremented pc plus twice offset
// - branch: one word, two cycles, flags untouched
// - top nibble 1000: bit set, bit/bank/register
// - read, set chosen bit, write back, one cycle
// - bank bit 0 access bank, 1 bank select
// - bank 0, extension on, f<=95: indexed offset
// - bit tests decode register, bit, bank bit
// - 1011 skips next word when bit clear
// - 1010 skips next word when bit set
`timescale 1ns/1ns
module bbd_core import bbd_pkg::*; #(
	parameter int PC_W = BBD_PC_W
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// program fetch
	output logic      [PC_W-1:0]        prog_addr,
	input  wire logic [BBD_INSTR_W-1:0] fetch_word,
	// addressing context from the rest of the core
	input  wire logic [BBD_BANK_W-1:0]  bank_select_register,
	input  wire logic                   ext_set_en,
	input  wire logic [BBD_DA_W-1:0]    index_base,
	// data memory preload, wins over the core write
	input  wire bbd_load_t              load,
	// execution view
	output logic [BBD_INSTR_W-1:0]      exec_word,
	output bbd_op_t                     exec_op,
	output logic [BBD_DA_W-1:0]         exec_addr,
	output logic                        branch_taken,
	output logic                        skip_taken,
	output logic                        cycle_end
);
	logic       rst_meta;
	logic       rst_n;
	bbd_state_t st;
	bbd_state_t next_st;
	logic [7:0] mem_rdata;
	logic [BBD_DA_W-1:0] eff_addr;
	bbd_op_t    dec_op;
	logic       core_we;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// opcode classes from the top nibble
	always_comb begin
		case (st.ir[BBD_OPC_HI:BBD_OPC_LO])
			BBD_OPC_BRA:  dec_op = BBD_OP_BRANCH;
			BBD_OPC_BSET: dec_op = BBD_OP_BITSET;
			BBD_OPC_TCLR: dec_op = BBD_OP_SKIPCLR;
			BBD_OPC_TSET: dec_op = BBD_OP_SKIPSET;
			default:      dec_op = BBD_OP_NONE;
		endcase
	end

	// operand address for the bit-oriented forms
	always_comb begin
		logic [7:0] f;
		f = st.ir[BBD_REG_HI:0];
		if (st.ir[BBD_AMODE_POS]) begin
			eff_addr = {bank_select_register, f};
		end else if (ext_set_en && f <= BBD_IDX_MAX) begin
			// wraps inside data space, as the pointer itself does
			eff_addr = index_base + {4'h0, f};
		end else if (f < BBD_ACC_SPLIT) begin
			eff_addr = {BBD_ACC_LO, f};
		end else begin
			eff_addr = {BBD_ACC_HI, f};
		end
	end

	always_comb begin
		logic signed [11:0] off2;
		logic               tbit;
		off2 = {st.ir[BBD_OFF_HI:0], 1'b0};
		tbit = st.rbyte[st.bsel];
		next_st = st;
		next_st.phase = st.phase + BBD_Q_STEP;
		next_st.branch_taken = 1'b0;
		next_st.skip_taken = 1'b0;
		next_st.cycle_end = 1'b0;
		case (st.phase)
			BBD_Q1: begin
				next_st.op = dec_op;
				next_st.addr = eff_addr;
				next_st.bsel = st.ir[BBD_BIT_HI:BBD_BIT_LO];
			end
			BBD_Q2: begin
				next_st.rbyte = mem_rdata;
			end
			BBD_Q3: begin
				// only the chosen bit changes, no flags are touched
				next_st.wbyte = st.rbyte | (BBD_BIT_ONE << st.bsel);
			end
			BBD_Q4: begin
				next_st.cycle_end = 1'b1;
				next_st.ir = fetch_word;
				next_st.pc = st.pc + PC_W'(BBD_PC_STEP);
				case (st.op)
					BBD_OP_BRANCH: begin
						// pc already points past this word
						next_st.pc = st.pc + PC_W'(off2);
						next_st.ir = BBD_NOP_WORD;
						next_st.branch_taken = 1'b1;
					end
					BBD_OP_SKIPCLR: begin
						if (!tbit) begin
							next_st.ir = BBD_NOP_WORD;
							next_st.skip_taken = 1'b1;
						end
					end
					BBD_OP_SKIPSET: begin
						if (tbit) begin
							next_st.ir = BBD_NOP_WORD;
							next_st.skip_taken = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{phase: BBD_Q1, pc: PC_W'(BBD_PC_RESET),
				ir: BBD_NOP_WORD, op: BBD_OP_NONE, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// write back in the last phase of the bit set
	assign core_we = (st.phase == BBD_Q4) && (st.op == BBD_OP_BITSET);

	bbd_mem #(
		.AW (BBD_DA_W),
		.DW (8)
	) u_mem (
		.clk   (clk),
		.we    (load.en | core_we),
		.waddr (load.en ? load.addr : st.addr),
		.wdata (load.en ? load.data : st.wbyte),
		.raddr (eff_addr),
		.rdata (mem_rdata)
	);

	assign prog_addr    = st.pc;
	assign exec_word    = st.ir;
	assign exec_op      = st.op;
	assign exec_addr    = st.addr;
	assign branch_taken = st.branch_taken;
	assign skip_taken   = st.skip_taken;
	assign cycle_end    = st.cycle_end;
endmodule

// ---- bbd_checker.sv ----
/* bbd_checker: timing and decode properties of bbd_core.
 * assumes binding to bbd_core; sees its ports only. */
`timescale 1ns/1ns
module bbd_checker import bbd_pkg::*; #(
	parameter int PC_W = BBD_PC_W
) (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   arst_n,
	// fetch and context
	input wire logic [PC_W-1:0]        prog_addr,
	input wire logic [BBD_BANK_W-1:0]  bank_select_register,
	input wire logic                   ext_set_en,
	input wire logic [BBD_DA_W-1:0]    index_base,
	// execution view
	input wire logic [BBD_INSTR_W-1:0] exec_word,
	input wire bbd_op_t                exec_op,
	input wire logic [BBD_DA_W-1:0]    exec_addr,
	input wire logic                   branch_taken,
	input wire logic                   skip_taken,
	input wire logic                   cycle_end
);
	wire logic bitop = exec_word[15:12] == BBD_OPC_BSET
		|| exec_word[15:13] == 3'h5;
	wire logic idx = ext_set_en && exec_word[7:0] <= BBD_IDX_MAX;
	wire logic dec = cycle_end && bitop;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_cyc; cycle_end |=> !cycle_end [*3] ##1 cycle_end; endproperty
	a_cyc: assert property (p_cyc) else $error("cycle length");
	property p_fl; branch_taken |-> cycle_end
		&& exec_op == BBD_OP_BRANCH && exec_word == BBD_NOP_WORD; endproperty
	a_fl: assert property (p_fl) else $error("branch flush");
	property p_tgt; branch_taken |-> prog_addr == $past(prog_addr)
		+ {{(PC_W-12){$past(exec_word[10])}}, $past(exec_word[10:0]), 1'b0};
	endproperty
	a_tgt: assert property (p_tgt) else $error("branch target");
	property p_stp; cycle_end && !branch_taken
		|-> prog_addr == $past(prog_addr) + BBD_PC_STEP; endproperty
	a_stp: assert property (p_stp) else $error("pc step");
	property p_skp; skip_taken |-> exec_word == BBD_NOP_WORD
		&& (exec_op == BBD_OP_SKIPCLR || exec_op == BBD_OP_SKIPSET); endproperty
	a_skp: assert property (p_skp) else $error("skip flush");
	property p_bra; cycle_end && exec_word[15:12] == BBD_OPC_BRA
		|=> exec_op == BBD_OP_BRANCH; endproperty
	a_bra: assert property (p_bra) else $error("branch decode");
	property p_bs; cycle_end && exec_word[15:12] == BBD_OPC_BSET
		|=> exec_op == BBD_OP_BITSET; endproperty
	a_bs: assert property (p_bs) else $error("bit set decode");
	property p_tst; cycle_end && exec_word[15:13] == 3'h5 |=> exec_op
		== (exec_word[12] ? BBD_OP_SKIPCLR : BBD_OP_SKIPSET); endproperty
	a_tst: assert property (p_tst) else $error("bit test decode");
	property p_bk; dec && exec_word[8] |=> exec_addr
		== {$past(bank_select_register), exec_word[7:0]}; endproperty
	a_bk: assert property (p_bk) else $error("bank address");
	property p_ac; dec && !exec_word[8] && !idx
		|=> exec_addr == {{4{exec_word[7]}}, exec_word[7:0]}; endproperty
	a_ac: assert property (p_ac) else $error("access address");
	property p_ix; dec && !exec_word[8] && idx
		|=> exec_addr == $past(index_base) + exec_word[7:0]; endproperty
	a_ix: assert property (p_ix) else $error("indexed address");
	cover property (branch_taken);
	cover property (skip_taken);
	cover property (dec && !exec_word[8] && idx);
endmodule

bind bbd_core bbd_checker #(.PC_W(PC_W)) u_chk (.clk, .arst_n, .prog_addr,
	.bank_select_register, .ext_set_en, .index_base, .exec_word, .exec_op,
	.exec_addr, .branch_taken, .skip_taken, .cycle_end);

// ---- test_branch_and_bit_op_decode.sv ----
/* test_branch_and_bit_op_decode: directed loop, then random words.
 * assumes bbd_core with its bound checker; drives all inputs itself. */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t mismatch", $time); end end
module test_branch_and_bit_op_decode import bbd_pkg::*;;
	logic        clk = 0, arst_n = 0, ext_set_en = 0;
	logic [3:0]  bank_select_register = 0;
	logic [11:0] index_base = 0, exec_addr;
	logic [15:0] fetch_word = 0, exec_word, rom [64];
	logic [20:0] prog_addr;
	bbd_load_t   load = '0;
	bbd_op_t     exec_op;
	logic        branch_taken, skip_taken, cycle_end;
	int          err_count = 0, tests_run = 0, rb, k;
	bbd_core dut (.clk, .arst_n, .prog_addr, .fetch_word,
		.bank_select_register, .ext_set_en, .index_base, .load,
		.exec_word, .exec_op, .exec_addr, .branch_taken, .skip_taken,
		.cycle_end);
	initial forever #50 clk = ~clk;
	always @(posedge clk) fetch_word <= #1 rom[prog_addr[6:1]];
	function automatic logic [20:0] exp_pc(int j);
		return (j == 7) ? 21'h0 : 21'(2 * (j + 1));
	endfunction
	task automatic conclude();
		$display("errors %0d, checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic next_ce();
		for (int i = 0; i < 12; i++) begin
			@(posedge clk) #1;
			if (cycle_end === 1'b1)
				return;
		end
		err_count++;
		conclude();
	endtask
	initial begin
		void'($urandom(96868));
		rb = $urandom % 8;
		foreach (rom[i]) rom[i] = BBD_NOP_WORD;
		// set, skip-if-set, trap, skip-if-clear on the set bit (no skip),
		// skip-if-clear on a clear bit, trap, branch back by 7
		rom[0] = 16'h8010 | 16'(rb << 9);
		rom[1] = 16'ha010 | 16'(rb << 9);
		rom[2] = 16'hd0ff;
		rom[3] = 16'hb010 | 16'(rb << 9);
		rom[4] = 16'hb011 | 16'(rb << 9);
		rom[5] = 16'hd0ff;
		rom[6] = 16'hd7f9;
		load = '{1'b1, 12'h011, 8'($urandom) & ~(8'h01 << rb)};
		@(posedge clk);
		#1 load = '{1'b1, 12'h010, 8'($urandom) & ~(8'h01 << rb)};
		@(posedge clk);
		#1 arst_n = 1;
		load.en = 0;
		for (k = 0; k < 32; k++) begin
			next_ce();
			`CHK(prog_addr, exp_pc(k % 8))
			`CHK(skip_taken, 1'(k % 8 inside {2, 5}))
			`CHK(skip_taken && prog_addr == 21'h00000c, 1'(k % 8 == 5))
			`CHK(branch_taken, 1'(k % 8 == 7))
			`CHK(exec_word === BBD_NOP_WORD, 1'(k % 8 inside {2, 5, 7}))
		end
		// mid-run reset, then random words and context
		arst_n = 0;
		foreach (rom[i]) rom[i] = 16'($urandom);
		#100 arst_n = 1;
		repeat (1200) begin
			@(posedge clk) #1;
			ext_set_en = 1'($urandom);
			bank_select_register = 4'($urandom);
			index_base = 12'($urandom);
			load = '{1'($urandom), 12'($urandom), 8'($urandom)};
		end
		conclude();
	end
endmodule
